// >>> src/ppco_params.svh
`ifndef PPCO_PARAMS_SVH
`define PPCO_PARAMS_SVH

// =====================================================================
// port geometry
`define PPCO_PORT_WIDTH     8

// =====================================================================
// register indexes on the plain register port
`define PPCO_ADDR_W         3
`define PPCO_ADDR_DIR       3'h0
`define PPCO_ADDR_OUT       3'h1
`define PPCO_ADDR_PULLUP    3'h2
`define PPCO_ADDR_INPUT     3'h3
`define PPCO_ADDR_CTRL      3'h4

// =====================================================================
// control register fields and reset values
`define PPCO_CTRL_BBM_BIT   0
`define PPCO_RST_DIR        8'h00
`define PPCO_RST_OUT        8'h00
`define PPCO_RST_PULLUP     8'h00
`define PPCO_RST_CTRL       1'h0

`endif

// >>> src/ppco_pkg.sv
`include "ppco_params.svh"

package ppco_pkg;
  typedef logic [`PPCO_PORT_WIDTH-1:0] ppco_port_t;
endpackage

// >>> src/ppco_port.sv
`timescale 1ns/1ps
`include "ppco_params.svh"

module ppco_port #(
  parameter int WIDTH = `PPCO_PORT_WIDTH
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  // register port
  input  wire logic [`PPCO_ADDR_W-1:0] reg_addr,
  input  wire logic [WIDTH-1:0]        reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [WIDTH-1:0]        reg_rdata,
  // sleep controller and interrupt logic
  input  wire logic                    sleep_deep,
  input  wire logic [WIDTH-1:0]        ext_int_enable,
  // alternative function overrides
  input  wire logic [WIDTH-1:0]        pullup_override_enable,
  input  wire logic [WIDTH-1:0]        pullup_override_value,
  input  wire logic [WIDTH-1:0]        direction_override_enable,
  input  wire logic [WIDTH-1:0]        direction_override_value,
  input  wire logic [WIDTH-1:0]        value_override_enable,
  input  wire logic [WIDTH-1:0]        value_override_value,
  input  wire logic [WIDTH-1:0]        toggle_override_enable,
  input  wire logic [WIDTH-1:0]        input_enable_override_enable,
  input  wire logic [WIDTH-1:0]        input_enable_override_value,
  output logic      [WIDTH-1:0]        alt_digital_input,
  output logic      [WIDTH-1:0]        alt_analog_path,
  // pad
  input  wire logic [WIDTH-1:0]        pad_in,
  output logic      [WIDTH-1:0]        pad_out,
  output logic      [WIDTH-1:0]        pad_oe,
  output logic      [WIDTH-1:0]        pad_pullup_en
);

  // =====================================================================
  // software registers and internal port signals
  ppco_pkg::ppco_port_t pin_direction_reg;
  ppco_pkg::ppco_port_t pin_out_value_reg;
  ppco_pkg::ppco_port_t pin_pullup_reg;
  logic                 break_before_make_enable_reg;
  ppco_pkg::ppco_port_t bbm_hold;
  ppco_pkg::ppco_port_t sync_latch_reg;
  ppco_pkg::ppco_port_t pin_input_reg;
  ppco_pkg::ppco_port_t pin_out_value_next;
  ppco_pkg::ppco_port_t dir_eff;
  ppco_pkg::ppco_port_t dir_prev_reg;
  ppco_pkg::ppco_port_t input_enable;
  ppco_pkg::ppco_port_t schmitt_out;

  logic wr_dir;
  logic wr_out;
  logic wr_pullup;
  logic wr_input;
  logic wr_ctrl;

  // address decode
  always_comb begin
    wr_dir    = 1'b0;
    wr_out    = 1'b0;
    wr_pullup = 1'b0;
    wr_input  = 1'b0;
    wr_ctrl   = 1'b0;
    if (reg_addr == `PPCO_ADDR_DIR) begin
      wr_dir = reg_wr;
    end else if (reg_addr == `PPCO_ADDR_OUT) begin
      wr_out = reg_wr;
    end else if (reg_addr == `PPCO_ADDR_PULLUP) begin
      wr_pullup = reg_wr;
    end else if (reg_addr == `PPCO_ADDR_INPUT) begin
      wr_input = reg_wr;
    end else if (reg_addr == `PPCO_ADDR_CTRL) begin
      wr_ctrl = reg_wr;
    end
  end

  // direction register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_direction_reg <= `PPCO_RST_DIR;
    end else if (wr_dir) begin
      pin_direction_reg <= reg_wdata;
    end
  end

  // output value: write, then input-bit toggle, then override toggle
  always_comb begin
    pin_out_value_next = pin_out_value_reg;
    if (wr_out) begin
      pin_out_value_next = reg_wdata;
    end else if (wr_input) begin
      pin_out_value_next = pin_out_value_reg ^ reg_wdata;
    end
    pin_out_value_next = pin_out_value_next ^ toggle_override_enable;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_out_value_reg <= `PPCO_RST_OUT;
    end else begin
      pin_out_value_reg <= pin_out_value_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_pullup_reg <= `PPCO_RST_PULLUP;
    end else if (wr_pullup) begin
      pin_pullup_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      break_before_make_enable_reg <= `PPCO_RST_CTRL;
    end else if (wr_ctrl) begin
      break_before_make_enable_reg <= reg_wdata[`PPCO_CTRL_BBM_BIT];
    end
  end

  // =====================================================================
  // driver enable and break-before-make
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      dir_eff[i] = direction_override_enable[i] ? direction_override_value[i] : pin_direction_reg[i];
    end
  end

  // one cycle hold on a rising enable; a falling one passes straight
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dir_prev_reg <= '0;
    end else begin
      dir_prev_reg <= dir_eff;
    end
  end

  always_comb begin
    bbm_hold = {WIDTH{break_before_make_enable_reg}} & dir_eff & ~dir_prev_reg;
  end

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      pad_oe[i] = ~rst & dir_eff[i] & ~bbm_hold[i];
      pad_out[i] = value_override_enable[i] ? value_override_value[i] : pin_out_value_reg[i];
      pad_pullup_en[i] = ~rst & (pullup_override_enable[i] ? pullup_override_value[i] : pin_pullup_reg[i]);
      input_enable[i] = input_enable_override_enable[i] ? input_enable_override_value[i]
                                                         : (~sleep_deep | ext_int_enable[i]);
      schmitt_out[i] = pad_in[i] & input_enable[i];
    end
  end

  assign alt_digital_input = schmitt_out;
  assign alt_analog_path = pad_in;

  // =====================================================================
  // input synchronizer
  // latch while clock high
  always_latch begin
    if (clk_sys) begin
      // non-blocking so the rising-edge register still sees the held value
      sync_latch_reg <= schmitt_out;
    end
  end

  // half to one and a half
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_input_reg <= '0;
    end else begin
      pin_input_reg <= sync_latch_reg;
    end
  end

  // =====================================================================
  // read data, one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == `PPCO_ADDR_DIR) begin
        reg_rdata <= pin_direction_reg;
      end else if (reg_addr == `PPCO_ADDR_OUT) begin
        reg_rdata <= pin_out_value_reg;
      end else if (reg_addr == `PPCO_ADDR_PULLUP) begin
        reg_rdata <= pin_pullup_reg;
      end else if (reg_addr == `PPCO_ADDR_INPUT) begin
        reg_rdata <= pin_input_reg;
      end else if (reg_addr == `PPCO_ADDR_CTRL) begin
        reg_rdata <= {{(WIDTH-1){1'b0}}, break_before_make_enable_reg};
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule // ppco_port

// >>> bench/ppco_port_assertions.sv
`timescale 1ns/1ps
module ppco_port_assertions (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [2:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       sleep_deep,
  input wire logic [7:0] ext_int_enable,
  input wire logic [7:0] pullup_override_enable,
  input wire logic [7:0] pullup_override_value,
  input wire logic [7:0] direction_override_enable,
  input wire logic [7:0] direction_override_value,
  input wire logic [7:0] value_override_enable,
  input wire logic [7:0] value_override_value,
  input wire logic [7:0] input_enable_override_enable,
  input wire logic [7:0] alt_digital_input,
  input wire logic [7:0] alt_analog_path,
  input wire logic [7:0] pad_in,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_calm;
    !sleep_deep && input_enable_override_enable == 8'h00 && $stable(pad_in);
  endsequence
  property p_rst_oe; disable iff (1'b0) rst |-> pad_oe == 8'h00; endproperty
  property p_rst_pu; disable iff (1'b0) rst |-> pad_pullup_en == 8'h00; endproperty
  property p_pu_ovr; ((pad_pullup_en ^ pullup_override_value) & pullup_override_enable) == 8'h00; endproperty
  property p_dir_ovr; (pad_oe & direction_override_enable & ~direction_override_value) == 8'h00; endproperty
  property p_val_ovr; ((pad_out ^ value_override_value) & value_override_enable & pad_oe) == 8'h00; endproperty
  property p_analog; alt_analog_path == pad_in; endproperty
  property p_clamp;
    sleep_deep |-> ((alt_digital_input ^ (pad_in & ext_int_enable)) & ~input_enable_override_enable) == 8'h00;
  endproperty
  property p_pin_read;
    s_calm [*3] ##0 (reg_rd && reg_addr == 3'h3) |=> reg_rdata == $past(pad_in);
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("pad driven in reset");
  a_rst_pu: assert property (p_rst_pu) else $error("pullup on in reset");
  a_pu_ovr: assert property (p_pu_ovr) else $error("pullup override lost");
  a_dir_ovr: assert property (p_dir_ovr) else $error("direction override lost");
  a_val_ovr: assert property (p_val_ovr) else $error("value override lost");
  a_analog: assert property (p_analog) else $error("analog path differs");
  a_clamp: assert property (p_clamp) else $error("sleep clamp wrong");
  a_pin_read: assert property (p_pin_read) else $error("input bit wrong");
endmodule // ppco_port_assertions

bind ppco_port ppco_port_assertions ppco_port_assertions_i (.*);

// >>> bench/ppco_pad_model.sv
`timescale 1ns/1ps
module ppco_pad_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup_en,
  input  wire logic [7:0] ext_drv,
  input  wire logic [7:0] ext_lvl,
  output logic      [7:0] pad_in
);
  logic [7:0] last = 8'h00;
  // a floating bit without pullup shows the inverse of its last level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_lvl) | (~pad_oe & ~ext_drv & (pad_pullup_en | ~last));
  always_ff @(posedge clk_sys) last <= pad_in;
endmodule // ppco_pad_model

// >>> bench/ppco_port_tb.sv
`timescale 1ns/1ps
module ppco_port_tb;
  logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, sleep_deep = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 0, ext_int_enable = 0, pullup_override_enable = 0, pullup_override_value = 0;
  logic [7:0] direction_override_enable = 0, direction_override_value = 0, value_override_enable = 0;
  logic [7:0] value_override_value = 0, toggle_override_enable = 0, input_enable_override_enable = 0;
  logic [7:0] input_enable_override_value = 0, ext_drv = 8'hff, ext_lvl = 0;
  logic [7:0] reg_rdata, alt_digital_input, alt_analog_path, pad_in, pad_out, pad_oe, pad_pullup_en;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  ppco_port ppco_port_i (.*);
  ppco_pad_model ppco_pad_model_i (.*);
  initial forever #2.5 clk_sys = ~clk_sys;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    #1;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, e);
  endtask
  task step;
    @(posedge clk_sys);
    #1;
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 1000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ==========
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'h0;
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
    wr(3'h1, 8'ha5);
    wr(3'h0, 8'h01);
    chk(pad_oe, 8'h01);
    chk(pad_out & pad_oe, 8'h01);
    wr(3'h3, 8'h0f);
    rd(3'h1, 8'haa);
    wr(3'h0, 8'hff);
    wr(3'h1, 8'h3c);
    rd(3'h3, 8'h3c);
    // direction writes kept four cycles apart
    wr(3'h0, 8'h01);
    wr(3'h4, 8'h01);
    wr(3'h0, 8'hf2);
    chk(pad_oe, 8'h00);
    step();
    chk(pad_oe, 8'hf2);
    wr(3'h4, 8'h00);
    @(posedge clk_sys) toggle_override_enable <= 8'h04;
    @(posedge clk_sys) toggle_override_enable <= 8'h00;
    rd(3'h1, 8'h38);
    @(posedge clk_sys);
    direction_override_enable <= 8'h0f;
    direction_override_value <= 8'h05;
    value_override_enable <= 8'h0f;
    value_override_value <= 8'h03;
    pullup_override_enable <= 8'h0f;
    pullup_override_value <= 8'h0a;
    step();
    chk(pad_oe, 8'hf5);
    chk(pad_out & pad_oe, 8'h31);
    chk(pad_pullup_en, 8'h0a);
    wr(3'h2, 8'hc0);
    chk(pad_pullup_en, 8'hca);
    wr(3'h0, 8'h00);
    @(posedge clk_sys);
    direction_override_enable <= 8'h00;
    ext_lvl <= 8'h96;
    rd(3'h3, 8'h96);
    chk(alt_digital_input, 8'h96);
    chk(alt_analog_path, 8'h96);
    @(posedge clk_sys);
    sleep_deep <= 1'h1;
    ext_int_enable <= 8'h06;
    input_enable_override_enable <= 8'h80;
    input_enable_override_value <= 8'h80;
    step();
    chk(alt_digital_input, 8'h86);
    wr(3'h0, 8'hff);
    @(posedge clk_sys) rst <= 1'h1;
    #1 chk(pad_oe, 8'h00);
    chk(pad_pullup_en, 8'h00);
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    rd(3'h2, 8'h00);
    tally_and_finish();
  end
endmodule // ppco_port_tb
